/* File: shared/cwm_defines.svh */
// Constants of the complementary waveform mode block: mode codes,
// control bit positions, reset values and register addresses.
// Assumes inclusion by bare name from package and design files.
`ifndef CWM_DEFINES_SVH
`define CWM_DEFINES_SVH

// Register addresses on the plain register port
`define CWM_ADDR_CTRL0 4'h0
`define CWM_ADDR_CTRL1 4'h1
`define CWM_ADDR_STEER 4'h2
`define CWM_ADDR_DBR 4'h3
`define CWM_ADDR_DBF 4'h4
`define CWM_ADDR_SHUT 4'h5
`define CWM_ADDR_STAT 4'h6

// Control 0 fields
`define CWM_EN_BIT 7
`define CWM_MODE_LSB 0
`define CWM_MODE_MSB 2

// Mode codes; half-bridge and push-pull codes are free choices
`define CWM_MODE_ASYNC 3'h0
`define CWM_MODE_SYNC 3'h1
`define CWM_MODE_FWD 3'h2
`define CWM_MODE_REV 3'h3
`define CWM_MODE_HALF 3'h4
`define CWM_MODE_PUSH 3'h5

// Shutdown register fields
`define CWM_SD_SRC_LSB 0
`define CWM_SD_SRC_MSB 1
`define CWM_SD_RESTART_BIT 2
`define CWM_SD_SOFT_BIT 3
`define CWM_SD_OVR_LSB 4
`define CWM_SD_OVR_MSB 7

// Dead-band register fields
`define CWM_DB_WIDTH 6
`define CWM_DB_EN_BIT 7

// Reset values
`define CWM_CTRL0_RST 8'h00
`define CWM_CTRL1_RST 8'h0f
`define CWM_STEER_RST 8'h00
`define CWM_DB_RST 8'h00
`define CWM_SHUT_RST 8'h00

`endif

/* File: shared/cwm_pkg.sv */
// Types of the complementary waveform mode block.
// Assumes cwm_defines.svh sits beside it.
`include "cwm_defines.svh"

package cwm_pkg;
    typedef logic [`CWM_MODE_MSB:`CWM_MODE_LSB] cwm_mode_t;
    typedef logic [`CWM_DB_WIDTH-1:0] cwm_db_t;
    typedef enum logic [1:0] {CWM_DB_IDLE, CWM_DB_RUN, CWM_DB_DONE} cwm_db_state_t;
endpackage

/* File: shared/cwm_db_if.sv */
// Interface between the mode logic and one dead-band delay unit.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none

interface cwm_db_if;
    logic start;
    logic enable;
    cwm_pkg::cwm_db_t count;
    logic busy;
    modport ctrl (output start, output enable, output count, input busy);
    modport unit (input start, input enable, input count, output busy);
endinterface

`default_nettype wire

/* File: design/cwm_deadband.sv */
// One dead-band counter: counts module clock periods from zero up to a
// programmed value after a start pulse, reporting busy meanwhile.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
`include "cwm_defines.svh"

module cwm_deadband (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic run_in,
    cwm_db_if.unit db
);
    cwm_pkg::cwm_db_state_t state_reg, state_next;
    cwm_pkg::cwm_db_t cnt_reg, cnt_next;

    // Count from zero to the programmed value; disabled gives no delay
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            cwm_pkg::CWM_DB_IDLE: begin
                if (db.start && db.enable && db.count != '0) begin
                    state_next = cwm_pkg::CWM_DB_RUN;
                    cnt_next = '0;
                end
            end
            cwm_pkg::CWM_DB_RUN: begin
                cnt_next = cnt_reg + 6'h01;
                if (cnt_next == db.count) begin
                    state_next = cwm_pkg::CWM_DB_DONE;
                end
            end
            cwm_pkg::CWM_DB_DONE: begin
                state_next = cwm_pkg::CWM_DB_IDLE;
            end
        endcase
        if (!run_in) begin
            state_next = cwm_pkg::CWM_DB_IDLE;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= cwm_pkg::CWM_DB_IDLE;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    assign db.busy = (state_reg == cwm_pkg::CWM_DB_RUN);
endmodule

`default_nettype wire

/* File: design/cwm_modes.sv */
// Mode logic of a complementary waveform generator with register port.
// Assumes synchronous inputs, one 20 MHz clock, a plain register master.
`timescale 1ns/1ns
`default_nettype none
`include "cwm_defines.svh"

module cwm_modes (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    input wire logic pulse_in,
    input wire logic [1:0] shutdown_src_in,
    output logic bridge_out_a,
    output logic bridge_out_b,
    output logic bridge_out_c,
    output logic bridge_out_d
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] wave_control_0_reg;
    logic [7:0] wave_control_1_reg;
    logic [7:0] steer_reg;
    logic [7:0] dbr_reg;
    logic [7:0] dbf_reg;
    logic [7:0] shut_reg;
    logic [7:0] rdata_reg, rdata_next;

    wire logic wr_ctrl0 = reg_write_in && reg_addr_in == `CWM_ADDR_CTRL0;
    wire logic wr_ctrl1 = reg_write_in && reg_addr_in == `CWM_ADDR_CTRL1;
    wire logic wr_steer = reg_write_in && reg_addr_in == `CWM_ADDR_STEER;
    wire logic wr_dbr = reg_write_in && reg_addr_in == `CWM_ADDR_DBR;
    wire logic wr_dbf = reg_write_in && reg_addr_in == `CWM_ADDR_DBF;
    wire logic wr_shut = reg_write_in && reg_addr_in == `CWM_ADDR_SHUT;

    wire logic enable = wave_control_0_reg[`CWM_EN_BIT];
    wire cwm_pkg::cwm_mode_t mode = wave_control_0_reg[`CWM_MODE_MSB:`CWM_MODE_LSB];
    wire logic [3:0] invert_sel_each = wave_control_1_reg[3:0];
    wire logic invert_sel_c = invert_sel_each[2];
    wire logic invert_sel_d = invert_sel_each[3];

    // Write side; mode writes take effect whenever done, software
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wave_control_0_reg <= `CWM_CTRL0_RST;
            wave_control_1_reg <= `CWM_CTRL1_RST;
            steer_reg <= `CWM_STEER_RST;
            dbr_reg <= `CWM_DB_RST;
            dbf_reg <= `CWM_DB_RST;
            shut_reg <= `CWM_SHUT_RST;
        end else begin
            if (wr_ctrl0) wave_control_0_reg <= reg_wdata_in;
            if (wr_ctrl1) wave_control_1_reg <= reg_wdata_in;
            if (wr_steer) steer_reg <= reg_wdata_in;
            if (wr_dbr) dbr_reg <= reg_wdata_in;
            if (wr_dbf) dbf_reg <= reg_wdata_in;
            if (wr_shut) shut_reg <= reg_wdata_in;
        end
    end

    // ------------------------------------------------------------
    // Input edges and shutdown
    // ------------------------------------------------------------
    logic in_prev_reg;
    logic shut_active_reg, shut_active_next;
    wire logic rise = pulse_in && !in_prev_reg;
    wire logic fall = !pulse_in && in_prev_reg;
    wire logic sd_src = |(shutdown_src_in & shut_reg[`CWM_SD_SRC_MSB:`CWM_SD_SRC_LSB]);
    wire logic sd_event = enable && (sd_src || shut_reg[`CWM_SD_SOFT_BIT]);
    wire logic [3:0] ovr_level = shut_reg[`CWM_SD_OVR_MSB:`CWM_SD_OVR_LSB];

    // Shutdown holds until restart: automatic on next rising edge once the
    // cause is gone, otherwise by software writing the shutdown register or clearing the enable bit
    always_comb begin
        shut_active_next = shut_active_reg;
        if (sd_event) begin
            shut_active_next = 1'b1;
        end else if (!enable) begin
            shut_active_next = 1'b0;
        end else if (shut_reg[`CWM_SD_RESTART_BIT] && rise) begin
            shut_active_next = 1'b0;
        end else if (!shut_reg[`CWM_SD_RESTART_BIT] && wr_shut) begin
            shut_active_next = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Steering, direction and push-pull state
    // ------------------------------------------------------------
    logic [3:0] steer_live_reg;
    logic dir_rev_reg;
    logic pp_sel_b_reg;
    logic pp_a_reg, pp_b_reg;
    wire logic full_mode = mode == `CWM_MODE_FWD || mode == `CWM_MODE_REV;
    wire logic dir_change = full_mode && enable && rise && (mode[0] != dir_rev_reg);

    // Steering copy: async follows the register, sync waits for a rise
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            steer_live_reg <= 4'h0;
        end else if (mode == `CWM_MODE_ASYNC) begin
            steer_live_reg <= steer_reg[3:0];
        end else if (rise) begin
            steer_live_reg <= steer_reg[3:0];
        end
    end
    // Async uses the register straight away, cutting a pulse if need be
    wire logic [3:0] steer_now = (mode == `CWM_MODE_ASYNC) ? steer_reg[3:0] : steer_live_reg;

    // Direction latched at a rising input edge when enabled in full-bridge mode, else follows mode bit 0
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dir_rev_reg <= 1'b0;
        end else if (!enable || !full_mode) begin
            dir_rev_reg <= mode[0];
        end else if (rise) begin
            dir_rev_reg <= mode[0];
        end
    end

    // Push-pull: toggle on each rise, first rise lands on A
    wire logic pp_reset = !enable || shut_active_reg || sd_event;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pp_sel_b_reg <= 1'b1;
        end else if (pp_reset) begin
            pp_sel_b_reg <= 1'b1;
        end else if (rise) begin
            pp_sel_b_reg <= !pp_sel_b_reg;
        end
    end
    // Route the pulse to the side chosen at its rising edge
    always_comb begin
        pp_a_reg = pulse_in && !pp_sel_b_next();
        pp_b_reg = pulse_in && pp_sel_b_next();
    end
    function automatic logic pp_sel_b_next();
        pp_sel_b_next = (rise && !pp_reset) ? !pp_sel_b_reg : pp_sel_b_reg;
    endfunction

    // ------------------------------------------------------------
    // Dead-band units
    // ------------------------------------------------------------
    cwm_db_if db_rise ();
    cwm_db_if db_fall ();
    wire logic half_mode = mode == `CWM_MODE_HALF;
    // Rising unit: half-bridge rise and reverse direction; falling unit:
    // half-bridge fall and forward direction
    assign db_rise.start = (half_mode && rise) || (dir_change && mode[0]);
    assign db_fall.start = (half_mode && fall) || (dir_change && !mode[0]);
    assign db_rise.enable = dbr_reg[`CWM_DB_EN_BIT];
    assign db_fall.enable = dbf_reg[`CWM_DB_EN_BIT];
    assign db_rise.count = dbr_reg[`CWM_DB_WIDTH-1:0];
    assign db_fall.count = dbf_reg[`CWM_DB_WIDTH-1:0];

    cwm_deadband u_db_rise (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .run_in(enable),
        .db(db_rise.unit)
    );
    cwm_deadband u_db_fall (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .run_in(enable),
        .db(db_fall.unit)
    );

    // ------------------------------------------------------------
    // Mode selection, polarity and output flops
    // ------------------------------------------------------------
    logic [3:0] sel_data;   // Active-true level per output, before polarity
    logic [3:0] steered;    // Which outputs polarity and shutdown apply to
    wire logic fb_dir = full_mode ? (dir_change ? mode[0] : dir_rev_reg) : 1'b0;
    // Hold the modulated output from the very edge that starts the dead band
    wire logic db_hold = db_rise.busy || db_fall.busy
                         || (db_rise.start && db_rise.enable && db_rise.count != '0)
                         || (db_fall.start && db_fall.enable && db_fall.count != '0);
    // Half-bridge: A rises after rising dead band, B after falling dead band
    wire logic hb_a = pulse_in && !db_rise.busy && !(half_mode && rise && db_rise.enable
                       && db_rise.count != '0);
    wire logic hb_b = !pulse_in && !db_fall.busy && !(half_mode && fall && db_fall.enable
                       && db_fall.count != '0);

    always_comb begin
        sel_data = 4'h0;
        steered = 4'hf;
        unique case (mode)
            `CWM_MODE_HALF: begin
                sel_data = {hb_b, hb_a, hb_b, hb_a};
            end
            `CWM_MODE_PUSH: begin
                sel_data = {pp_b_reg, pp_a_reg, pp_b_reg, pp_a_reg};
            end
            `CWM_MODE_FWD, `CWM_MODE_REV: begin
                if (!fb_dir) begin
                    sel_data = {pulse_in && !db_hold, 1'b0, 1'b0, 1'b1};
                end else begin
                    sel_data = {1'b0, 1'b1, pulse_in && !db_hold, 1'b0};
                end
            end
            `CWM_MODE_ASYNC, `CWM_MODE_SYNC: begin
                steered = steer_now;
                sel_data = {4{pulse_in}} & steer_now;
            end
            default: begin
                sel_data = 4'h0;
            end
        endcase
    end

    // Polarity after selection; override levels bypass polarity
    logic [3:0] pin_next, pin_reg;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!enable) begin
                pin_next[i] = !invert_sel_each[i];
            end else if (steered[i] && (shut_active_reg || sd_event)) begin
                pin_next[i] = ovr_level[i];
            end else if (steered[i]) begin
                pin_next[i] = sel_data[i] ^ !invert_sel_each[i];
            end else begin
                pin_next[i] = ovr_level[i];
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            in_prev_reg <= 1'b0;
            shut_active_reg <= 1'b0;
            pin_reg <= 4'h0;
            rdata_reg <= 8'h00;
        end else begin
            in_prev_reg <= pulse_in;
            shut_active_reg <= shut_active_next;
            pin_reg <= pin_next;
            rdata_reg <= rdata_next;
        end
    end

    assign bridge_out_a = pin_reg[0];
    assign bridge_out_b = pin_reg[1];
    assign bridge_out_c = pin_reg[2];
    assign bridge_out_d = pin_reg[3];

    // ------------------------------------------------------------
    // Read side
    // ------------------------------------------------------------
    wire logic [7:0] status = {3'h0, db_fall.busy, db_rise.busy, dir_rev_reg,
                               pp_sel_b_reg, shut_active_reg};
    always_comb begin
        rdata_next = 8'h00;
        if (reg_read_in) begin
            unique case (reg_addr_in)
                `CWM_ADDR_CTRL0: rdata_next = wave_control_0_reg;
                `CWM_ADDR_CTRL1: rdata_next = wave_control_1_reg;
                `CWM_ADDR_STEER: rdata_next = steer_reg;
                `CWM_ADDR_DBR: rdata_next = dbr_reg;
                `CWM_ADDR_DBF: rdata_next = dbf_reg;
                `CWM_ADDR_SHUT: rdata_next = shut_reg;
                `CWM_ADDR_STAT: rdata_next = status;
                default: rdata_next = 8'h00;
            endcase
        end
    end
    assign reg_rdata_out = rdata_reg;
    // Unused upper bits of control 1 and steering read back as written
    wire logic unused_ok = invert_sel_c ^ invert_sel_d;
endmodule

`default_nettype wire

/* File: verification/cwm_modes_asserts.sv */
// Concurrent checks on the ports of the waveform mode block.
// Assumes a bind from tb; it mirrors control writes itself.
`timescale 1ns/1ns
`default_nettype none
`include "cwm_defines.svh"

module cwm_modes_asserts (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic pulse_in,
    input wire logic [1:0] shutdown_src_in,
    input wire logic bridge_out_a,
    input wire logic bridge_out_b,
    input wire logic bridge_out_c,
    input wire logic bridge_out_d
);
    // ----------------------------------------
    // Configuration mirror
    // ----------------------------------------
    logic en_reg;
    logic [2:0] mode_reg;
    logic [3:0] pol_reg;
    logic skip_reg;
    logic pulse_reg;
    logic rose_reg;
    logic [7:0] wr_cnt_reg;
    logic [7:0] rise_cnt_reg;
    logic dbsd_hit;
    logic armed;
    logic [3:0] act;

    // Dead band or shutdown reshape outputs, so later checks stand down
    assign dbsd_hit = (reg_addr_in >= `CWM_ADDR_DBR) && (reg_addr_in <= `CWM_ADDR_SHUT)
        && (reg_wdata_in != 8'h00);
    assign act = {bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a} ~^ pol_reg;
    assign armed = rose_reg && (rise_cnt_reg >= 8'h03) && en_reg && !skip_reg;

    // Track enable, mode and polarity as software writes them
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            en_reg <= 1'b0;
            mode_reg <= 3'h0;
            pol_reg <= 4'hf;
            skip_reg <= 1'b0;
        end else if (reg_write_in) begin
            if (reg_addr_in == `CWM_ADDR_CTRL0) begin
                en_reg <= reg_wdata_in[`CWM_EN_BIT];
                mode_reg <= reg_wdata_in[2:0];
            end
            if (reg_addr_in == `CWM_ADDR_CTRL1) begin
                pol_reg <= reg_wdata_in[3:0];
            end
            skip_reg <= skip_reg | dbsd_hit;
        end
    end

    // Age since last write and since the first input rise after it
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pulse_reg <= 1'b0;
            rose_reg <= 1'b0;
            wr_cnt_reg <= 8'h00;
            rise_cnt_reg <= 8'h00;
        end else begin
            pulse_reg <= pulse_in;
            rose_reg <= !reg_write_in && (rose_reg || (pulse_in && !pulse_reg));
            if (reg_write_in) begin
                wr_cnt_reg <= 8'h00;
                rise_cnt_reg <= 8'h00;
            end else begin
                wr_cnt_reg <= (wr_cnt_reg == 8'hff) ? wr_cnt_reg : wr_cnt_reg + 8'h01;
                rise_cnt_reg <= (rose_reg && rise_cnt_reg != 8'hff) ? rise_cnt_reg + 8'h01
                    : rise_cnt_reg;
            end
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    idle_level_a: assert property (!en_reg && !skip_reg && wr_cnt_reg >= 8'h02
        |-> act == 4'h0) else $error("disabled outputs not inactive");
    fwd_static_a: assert property (armed && mode_reg == `CWM_MODE_FWD
        |-> act[2:0] == 3'b001) else $error("forward static levels wrong");
    fwd_follow_a: assert property (armed && mode_reg == `CWM_MODE_FWD
        |-> act[3] == $past(pulse_in)) else $error("forward D not following input");
    rev_pattern_a: assert property (armed && mode_reg == `CWM_MODE_REV
        |-> act[3] == 1'b0 && act[2] && !act[0] && act[1] == $past(pulse_in))
        else $error("reverse pattern wrong");
    half_pair_a: assert property (armed && mode_reg == `CWM_MODE_HALF
        |-> act[1:0] == {!$past(pulse_in), $past(pulse_in)}) else $error("half pair wrong");
    half_copy_a: assert property (armed && mode_reg == `CWM_MODE_HALF
        |-> act[3:2] == act[1:0]) else $error("half C D not copying A B");
    push_route_a: assert property (armed && mode_reg == `CWM_MODE_PUSH
        |-> (act[0] ^ act[1]) == $past(pulse_in) && !(act[0] && act[1]))
        else $error("push pulse not on exactly one output");
    push_copy_a: assert property (armed && mode_reg == `CWM_MODE_PUSH
        |-> act[3:2] == act[1:0]) else $error("push C D not copying A B");

    cover property (armed && mode_reg == `CWM_MODE_FWD && pulse_in);
    cover property (armed && mode_reg == `CWM_MODE_REV && pulse_in);
    cover property (armed && mode_reg == `CWM_MODE_PUSH && act[1]);
endmodule

`default_nettype wire

/* File: verification/cwm_bridge_model.sv */
// Switch drivers of an H bridge: legs A/B and C/D each pair high and low side.
// Assumes pol_in mirrors the polarity setting written by the bench.
`timescale 1ns/1ns
`default_nettype none

module cwm_bridge_model (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] pol_in,
    input wire logic [3:0] leg_in,
    output logic fault_out,
    output logic [7:0] shoot_cnt_out
);
    // ----------------------------------------
    // Shoot-through watch
    // ----------------------------------------
    logic [3:0] on;

    // A leg with both switches on shorts the supply; flag it as a fault
    assign on = leg_in ~^ pol_in;
    assign fault_out = (on[0] && on[1]) || (on[2] && on[3]);

    // Count short cycles so the bench can demand none at the end
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shoot_cnt_out <= 8'h00;
        end else if (fault_out) begin
            shoot_cnt_out <= shoot_cnt_out + 8'h01;
        end
    end
endmodule

`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench: register port tasks and one sequence per mode.
// Assumes design, checker and bridge model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "cwm_defines.svh"

module tb;
    logic core_clk_in;
    logic rstn_in;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic pulse;
    logic sd1;
    logic [3:0] pol;
    wire logic [7:0] rdata;
    wire logic [3:0] outs;
    wire logic fault;
    wire logic [7:0] shoot;
    int failures;
    int num_checks;

    cwm_modes cwm_modes_inst (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
        .pulse_in(pulse), .shutdown_src_in({sd1, fault}), .bridge_out_a(outs[0]),
        .bridge_out_b(outs[1]), .bridge_out_c(outs[2]), .bridge_out_d(outs[3])
    );

    cwm_bridge_model cwm_bridge_model_inst (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in), .pol_in(pol), .leg_in(outs),
        .fault_out(fault), .shoot_cnt_out(shoot)
    );

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Strobe dropped then one idle cycle, so no signal is set twice at once
    task automatic wr_reg(input logic [3:0] ad, input logic [7:0] dt);
        addr <= ad;
        wdata <= dt;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
        tick(1);
    endtask

    task automatic rd_chk(input logic [3:0] ad, input logic [7:0] exp);
        addr <= ad;
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        check(rdata, exp);
        tick(1);
    endtask

    // Mode changes go through disable first, as software must
    task automatic set_mode(input logic [2:0] m);
        wr_reg(`CWM_ADDR_CTRL0, {5'h00, m});
        wr_reg(`CWM_ADDR_CTRL0, {5'h10, m});
    endtask

    task automatic act_chk(input logic [3:0] act);
        check({4'h0, outs}, {4'h0, act ~^ pol});
    endtask

    task automatic pset(input logic v);
        pulse <= v;
        tick(3);
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end

    // Cut a hang short well beyond the fewer than two hundred cycles needed
    initial begin
        #(3000 * 50);
        failures++;
        $display("watchdog expired");
        test_done();
    end

    initial begin
        rstn_in <= 1'b0;
        addr <= 4'h0;
        wdata <= 8'h00;
        wr <= 1'b0;
        rd <= 1'b0;
        pulse <= 1'b0;
        sd1 <= 1'b0;
        pol <= 4'hf;
        repeat (12) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        tick(2);
        for (int i = 0; i < 8; i++) begin
            // Sequencer parks on B, so the first pulse lands on A
            rd_chk(i[3:0], (i == 1) ? 8'h0f : (i == 6) ? 8'h02 : 8'h00);
        end
        wr_reg(4'h7, 8'h5a);
        rd_chk(4'h7, 8'h00);
        $display("register test done");
        pol <= 4'h5;
        wr_reg(`CWM_ADDR_CTRL1, 8'h05);
        act_chk(4'b0000);
        wr_reg(`CWM_ADDR_STEER, 8'h0f);
        set_mode(`CWM_MODE_FWD);
        pset(1'b1);
        act_chk(4'b1001);
        pset(1'b0);
        act_chk(4'b0001);
        wr_reg(`CWM_ADDR_CTRL0, 8'h83);
        act_chk(4'b0001);
        pset(1'b1);
        act_chk(4'b0110);
        pset(1'b0);
        act_chk(4'b0100);
        $display("full bridge test done");
        set_mode(`CWM_MODE_HALF);
        pset(1'b1);
        act_chk(4'b0101);
        pset(1'b0);
        act_chk(4'b1010);
        $display("half bridge test done");
        set_mode(`CWM_MODE_PUSH);
        for (int i = 0; i < 3; i++) begin
            pset(1'b1);
            act_chk((i == 1) ? 4'b1010 : 4'b0101);
            pset(1'b0);
            act_chk(4'b0000);
        end
        set_mode(`CWM_MODE_PUSH);
        pset(1'b1);
        act_chk(4'b0101);
        pset(1'b0);
        $display("push pull test done");
        // Unsteered B overrides high: active low, so its switch stays off
        wr_reg(`CWM_ADDR_SHUT, 8'h20);
        wr_reg(`CWM_ADDR_STEER, 8'h01);
        set_mode(`CWM_MODE_ASYNC);
        pset(1'b1);
        check({4'h0, outs}, 8'h03);
        wr_reg(`CWM_ADDR_STEER, 8'h00);
        check({4'h0, outs}, 8'h02);
        pset(1'b0);
        set_mode(`CWM_MODE_SYNC);
        pset(1'b1);
        wr_reg(`CWM_ADDR_STEER, 8'h01);
        check({4'h0, outs}, 8'h02);
        pset(1'b0);
        pset(1'b1);
        check({4'h0, outs}, 8'h03);
        pset(1'b0);
        $display("steering test done");
        wr_reg(`CWM_ADDR_DBR, 8'h84);
        wr_reg(`CWM_ADDR_DBF, 8'h84);
        set_mode(`CWM_MODE_HALF);
        pulse <= 1'b1;
        tick(2);
        act_chk(4'b0000);
        tick(2);
        act_chk(4'b0000);
        tick(2);
        act_chk(4'b0101);
        pulse <= 1'b0;
        tick(2);
        act_chk(4'b0000);
        tick(4);
        act_chk(4'b1010);
        set_mode(`CWM_MODE_REV);
        wr_reg(`CWM_ADDR_CTRL0, 8'h82);
        pulse <= 1'b1;
        tick(2);
        act_chk(4'b0001);
        tick(4);
        act_chk(4'b1001);
        pulse <= 1'b0;
        $display("dead band test done");
        wr_reg(`CWM_ADDR_SHUT, 8'hf2);
        sd1 <= 1'b1;
        tick(3);
        check({4'h0, outs}, 8'h0f);
        sd1 <= 1'b0;
        tick(3);
        check({4'h0, outs}, 8'h0f);
        wr_reg(`CWM_ADDR_SHUT, 8'hf2);
        act_chk(4'b0001);
        check(shoot, 8'h00);
        $display("shutdown test done");
        test_done();
    end
endmodule

bind cwm_modes cwm_modes_asserts cwm_modes_asserts_inst (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .pulse_in(pulse_in), .shutdown_src_in(shutdown_src_in),
    .bridge_out_a(bridge_out_a), .bridge_out_b(bridge_out_b), .bridge_out_c(bridge_out_c),
    .bridge_out_d(bridge_out_d)
);

`default_nettype wire
